/* File: rtl/aisel_params.svh */
`ifndef AISEL_PARAMS_SVH
`define AISEL_PARAMS_SVH

// Register indices; byte address is four times the index
`define AISEL_IDX_RESULT_LOW   8'h78
`define AISEL_IDX_RESULT_HIGH  8'h79
`define AISEL_IDX_CONV_CTRL    8'h7A
`define AISEL_IDX_CTRL_B       8'h7B
`define AISEL_IDX_INPUT_SEL    8'h7C
`define AISEL_IDX_IRQ_STATUS   8'h80
`define AISEL_IDX_IRQ_CLEAR    8'h81
`define AISEL_IDX_IRQ_ENABLE   8'h82

// Input select fields
`define AISEL_REF_HI           7
`define AISEL_REF_LO           6
`define AISEL_ALIGN_BIT        5
`define AISEL_CHAN_HI          4

// Control B fields
`define AISEL_CMP_MUX_BIT      6
`define AISEL_EXT_BIT          3
`define AISEL_TRIG_HI          2
`define AISEL_CTRL_B_MASK      8'h4F

// Conversion control fields
`define AISEL_START_BIT        0
`define AISEL_AUTO_BIT         1
`define AISEL_BUSY_BIT         2

// Reset values
`define AISEL_INPUT_SEL_RST    8'h00
`define AISEL_CTRL_B_RST       8'h00

// Bus answers
`define AISEL_RESP_OKAY        2'h0
`define AISEL_RESP_SLVERR      2'h2

`endif

/* File: rtl/aisel_pkg.sv */
package aisel_pkg;

    // Reference source choice
    typedef enum logic [1:0] {
        AISEL_REF_PIN    = 2'h0,
        AISEL_REF_SUPPLY = 2'h1,
        AISEL_REF_INT_1V1 = 2'h2,
        AISEL_REF_INT_2V56 = 2'h3
    } aisel_ref_e;

    // Gain stage choice
    typedef enum logic [1:0] {
        AISEL_GAIN_1X   = 2'h0,
        AISEL_GAIN_10X  = 2'h1,
        AISEL_GAIN_200X = 2'h2
    } aisel_gain_e;

    // Conversion tracking
    typedef enum logic [1:0] {
        AISEL_IDLE = 2'h0,
        AISEL_CONV = 2'h1
    } aisel_state_e;

    // Routing presented to the analog front end
    typedef struct packed {
        logic        valid;
        logic        diff;
        aisel_gain_e gain;
        logic [3:0]  pos;
        logic [3:0]  neg;
    } aisel_route_s;

endpackage

/* File: rtl/aisel_top.sv */
// Summary of operation
// - Bits 7:6 pick reference source
// - Reference/channel writes wait until conversion completes
// - Bit 5 selects left or right alignment
// - Alignment change shows at once
// - Six-bit code from low five plus extension
// - Extension write held until conversion ends
// - Reduced-pin variant ignores extension bit
// - Codes 0-7 single-ended inputs 0-7
// - Codes 8-15 gained differential pairs
// - Codes 16-29 unity-gain differential pairs
// - Differential result 10-bit two's complement, saturating
// - Input select at 0x7C, RW, reset zero
// - Control B at 0x7B, reserved bits zero
// - Auto trigger starts on selected rising edge
// - Done flag set when result updated
`include "aisel_params.svh"
`timescale 1ns/10ps
`default_nettype none

module aisel_top
    import aisel_pkg::*;
#(
    parameter int ADDR_W      = 12,
    parameter bit HAS_EXT_SEL = 1'b1
)
(
    // Clock, reset, enable
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Converter core
    input  wire logic              conv_done,
    input  wire logic signed [10:0] conv_raw,
    output var  logic              conv_start,
    // Analog routing
    output var  aisel_ref_e        active_ref,
    output var  aisel_route_s      active_route,
    output var  logic              comparator_mux_enable,
    // Trigger pins and interrupt
    input  wire logic [7:0]        trig_pins,
    output var  logic              irq
);

    // Code to routing decode
    function automatic aisel_route_s decode(input logic [5:0] code);
        aisel_route_s r;
        logic [3:0]   base;
        r    = '0;
        base = {code[5], 3'h0};
        unique case (code[4:3])
            2'h0:
            begin
                r.valid = 1'b1;
                r.pos   = base + {1'b0, code[2:0]};
            end
            2'h1:
            begin
                r.valid = 1'b1;
                r.diff  = 1'b1;
                r.neg   = base + {2'h0, code[2], 1'b0};
                r.pos   = base + {2'h0, code[2], code[0]};
                r.gain  = code[1] ? AISEL_GAIN_200X : AISEL_GAIN_10X;
            end
            2'h2:
            begin
                r.valid = 1'b1;
                r.diff  = 1'b1;
                r.pos   = base + {1'b0, code[2:0]};
                r.neg   = base + 4'h1;
            end
            2'h3:
            begin
                r.valid = (code[2:0] < 3'h6);
                r.diff  = r.valid;
                r.pos   = base + {1'b0, code[2:0]};
                r.neg   = base + 4'h2;
            end
        endcase
        return r;
    endfunction

    // Registers
    logic [7:0]    input_sel_reg;
    logic [7:0]    ctrl_b_reg;
    logic          auto_reg;
    logic [9:0]    result_reg;
    logic          status_reg;
    logic          enable_reg;
    logic [5:0]    active_code_reg;
    aisel_state_e  state_reg;
    logic [7:0]    trig_s1_reg;
    logic [7:0]    trig_s2_reg;
    logic          trig_prev_reg;
    logic          aw_got_reg;
    logic          w_got_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0]   wdata_reg;
    logic          wstrb0_reg;

    // Write decode
    wire       wr_fire   = aw_got_reg && w_got_reg && !s_axi_bvalid;
    wire [7:0] wr_idx    = awaddr_reg[9:2];
    wire       wr_lane   = wr_fire && wstrb0_reg;
    wire [7:0] wr_byte   = wdata_reg[7:0];
    wire       wr_in_sel = wr_lane && (wr_idx == `AISEL_IDX_INPUT_SEL);
    wire       wr_ctrl_b = wr_lane && (wr_idx == `AISEL_IDX_CTRL_B);
    wire       wr_conv   = wr_lane && (wr_idx == `AISEL_IDX_CONV_CTRL);
    wire       wr_clear  = wr_lane && (wr_idx == `AISEL_IDX_IRQ_CLEAR);
    wire       wr_enable = wr_lane && (wr_idx == `AISEL_IDX_IRQ_ENABLE);
    wire       wr_known  = (wr_idx == `AISEL_IDX_INPUT_SEL) || (wr_idx == `AISEL_IDX_CTRL_B)
                        || (wr_idx == `AISEL_IDX_CONV_CTRL) || (wr_idx == `AISEL_IDX_IRQ_CLEAR)
                        || (wr_idx == `AISEL_IDX_IRQ_ENABLE) || (wr_idx == `AISEL_IDX_RESULT_LOW)
                        || (wr_idx == `AISEL_IDX_RESULT_HIGH) || (wr_idx == `AISEL_IDX_IRQ_STATUS);

    // Live selection fields
    wire       ext_bit   = HAS_EXT_SEL ? ctrl_b_reg[`AISEL_EXT_BIT] : 1'b0;
    wire [5:0] live_code = {ext_bit, input_sel_reg[`AISEL_CHAN_HI:0]};
    wire       left_al   = input_sel_reg[`AISEL_ALIGN_BIT];
    wire       busy      = (state_reg == AISEL_CONV);

    // Trigger edge on the selected synchronised pin
    wire [2:0] trig_sel  = ctrl_b_reg[`AISEL_TRIG_HI:0];
    wire       trig_now  = trig_s2_reg[trig_sel];
    wire       trig_edge = trig_now && !trig_prev_reg;
    wire       sw_start  = wr_conv && wr_byte[`AISEL_START_BIT];
    wire       start_go  = !busy && (sw_start || (auto_reg && trig_edge));
    wire       done_go   = busy && conv_done;

    // Result saturation into 10 bits
    wire       raw_hi_d  = (conv_raw > 11'sd511);
    wire       raw_lo_d  = (conv_raw < -11'sd512);
    wire [9:0] sat_diff  = raw_hi_d ? 10'h1FF : (raw_lo_d ? 10'h200 : conv_raw[9:0]);
    wire [9:0] sat_se    = conv_raw[10] ? 10'h000 : conv_raw[9:0];
    wire [9:0] sat_val   = active_route.diff ? sat_diff : sat_se;

    // Result byte presentation follows the live alignment bit
    wire [7:0] res_low   = left_al ? {result_reg[1:0], 6'h00} : result_reg[7:0];
    wire [7:0] res_high  = left_al ? result_reg[9:2] : {6'h00, result_reg[9:8]};

    // Flag next value, set beats clear
    wire       status_next = done_go || (status_reg && !(wr_clear && wr_byte[0]));

    // Read decode
    wire [7:0] rd_idx = s_axi_araddr[9:2];
    logic [7:0] rd_byte;
    logic       rd_ok;
    always_comb
    begin
        rd_ok   = 1'b1;
        rd_byte = 8'h00;
        unique case (rd_idx)
            `AISEL_IDX_INPUT_SEL:   rd_byte = input_sel_reg;
            `AISEL_IDX_CTRL_B:      rd_byte = ctrl_b_reg;
            `AISEL_IDX_RESULT_LOW:  rd_byte = res_low;
            `AISEL_IDX_RESULT_HIGH: rd_byte = res_high;
            `AISEL_IDX_CONV_CTRL:   rd_byte = {5'h00, busy, auto_reg, busy};
            `AISEL_IDX_IRQ_STATUS:  rd_byte = {7'h00, status_reg};
            `AISEL_IDX_IRQ_ENABLE:  rd_byte = {7'h00, enable_reg};
            `AISEL_IDX_IRQ_CLEAR:   rd_byte = 8'h00;
            default:                rd_ok   = 1'b0;
        endcase
    end

    // Write channel capture, either order
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            awaddr_reg   <= '0;
            wdata_reg    <= 32'h0000_0000;
            wstrb0_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AISEL_RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else if (ce)
        begin
            s_axi_awready <= !aw_got_reg && !(s_axi_awvalid && s_axi_awready) && !wr_fire;
            s_axi_wready  <= !w_got_reg && !(s_axi_wvalid && s_axi_wready) && !wr_fire;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_reg  <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire)
            begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `AISEL_RESP_OKAY : `AISEL_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `AISEL_RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_ok ? `AISEL_RESP_OKAY : `AISEL_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Software registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            input_sel_reg <= `AISEL_INPUT_SEL_RST;
            ctrl_b_reg    <= `AISEL_CTRL_B_RST;
            auto_reg      <= 1'b0;
            enable_reg    <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_in_sel)
                input_sel_reg <= wr_byte;
            if (wr_ctrl_b)
                ctrl_b_reg <= wr_byte & `AISEL_CTRL_B_MASK;
            if (wr_conv)
                auto_reg <= wr_byte[`AISEL_AUTO_BIT];
            if (wr_enable)
                enable_reg <= wr_byte[0];
        end
    end

    // Conversion tracking with frozen selection, trigger synchroniser and edge history
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            trig_s1_reg     <= 8'h00;
            trig_s2_reg     <= 8'h00;
            trig_prev_reg   <= 1'b0;
            state_reg       <= AISEL_IDLE;
            conv_start      <= 1'b0;
            active_code_reg <= 6'h00;
            active_ref      <= AISEL_REF_PIN;
            active_route    <= decode(6'h00);
            result_reg      <= 10'h000;
            status_reg      <= 1'b0;
            irq             <= 1'b0;
        end
        else if (ce)
        begin
            trig_s1_reg   <= trig_pins;
            trig_s2_reg   <= trig_s1_reg;
            trig_prev_reg <= trig_now;
            conv_start <= start_go;
            status_reg <= status_next;
            irq        <= status_next && enable_reg;
            if (!busy)
            begin
                active_code_reg <= live_code;
                active_ref      <= aisel_ref_e'(input_sel_reg[`AISEL_REF_HI:`AISEL_REF_LO]);
                active_route    <= decode(live_code);
            end
            unique case (state_reg)
                AISEL_IDLE:
                    if (start_go)
                        state_reg <= AISEL_CONV;
                AISEL_CONV:
                    if (conv_done)
                    begin
                        state_reg  <= AISEL_IDLE;
                        result_reg <= sat_val;
                    end
                default:
                    state_reg <= AISEL_IDLE;
            endcase
        end
    end

    assign comparator_mux_enable = ctrl_b_reg[`AISEL_CMP_MUX_BIT];

    // Checks
    a_sel_held_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
        busy && !conv_done |=> $stable(active_code_reg) && $stable(active_ref))
        else $error("selection changed during conversion");
    a_sel_follows_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && !busy |=> active_code_reg == $past(live_code))
        else $error("selection did not follow registers while idle");
    a_ref_applied: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && !busy |=> active_ref == $past(input_sel_reg[7:6]))
        else $error("reference not applied");
    a_ext_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
        !HAS_EXT_SEL |-> !active_code_reg[5])
        else $error("extension bit used on reduced variant");
    a_single_route: assert property (@(posedge core_clk) disable iff (!rst_n)
        active_code_reg < 6'h08 |-> !active_route.diff && active_route.gain == AISEL_GAIN_1X
            && active_route.pos == {1'b0, active_code_reg[2:0]})
        else $error("single-ended route wrong");
    a_gain_pairs: assert property (@(posedge core_clk) disable iff (!rst_n)
        active_code_reg[5:3] == 3'h1 |-> active_route.diff && active_route.gain != AISEL_GAIN_1X)
        else $error("gained pair route wrong");
    a_unity_pairs: assert property (@(posedge core_clk) disable iff (!rst_n)
        active_code_reg >= 6'h10 && active_code_reg <= 6'h19
            |-> active_route.diff && active_route.gain == AISEL_GAIN_1X)
        else $error("unity pair route wrong");
    a_diff_saturate: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && done_go && active_route.diff && conv_raw > 11'sd511 |=> result_reg == 10'h1FF)
        else $error("positive full scale not saturated");
    a_done_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && done_go |=> status_reg && !busy)
        else $error("done flag not set");
    a_auto_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && !busy && auto_reg && trig_edge |=> conv_start ##1 1'b1)
        else $error("trigger edge did not start conversion");
    a_ctrl_b_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_b_reg[7] == 1'b0 && ctrl_b_reg[5:4] == 2'h0)
        else $error("reserved control bits set");
    c_auto_conv: cover property (@(posedge core_clk) disable iff (!rst_n)
        auto_reg && trig_edge && !busy ##[1:40] done_go);
    c_held_write: cover property (@(posedge core_clk) disable iff (!rst_n)
        busy && wr_in_sel ##[1:40] done_go);
    c_irq_raise: cover property (@(posedge core_clk) disable iff (!rst_n)
        enable_reg && done_go ##1 irq);

endmodule

`default_nettype wire

/* File: tb/aisel_conv_model.sv */
`timescale 1ns/10ps
`default_nettype none

module aisel_conv_model
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Control from the block and from the bench
    input  wire logic               conv_start,
    input  wire logic [7:0]         delay,
    input  wire logic signed [10:0] raw_in,
    // Result towards the block
    output var  logic               conv_done,
    output var  logic signed [10:0] conv_raw
);
    logic       busy;
    logic [7:0] cnt;

    // Converter core: ends each started conversion delay plus one cycles after the start;
    // raw bus toggles outside the done cycle so stale data never looks valid
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            busy      <= 1'b0;
            cnt       <= 8'h00;
            conv_done <= 1'b0;
            conv_raw  <= 11'h000;
        end
        else
        begin
            conv_done <= 1'b0;
            conv_raw  <= ~conv_raw;
            if (conv_start)
            begin
                busy <= 1'b1;
                cnt  <= delay;
            end
            else if (busy && cnt == 8'h00)
            begin
                busy      <= 1'b0;
                conv_done <= 1'b1;
                conv_raw  <= raw_in;
            end
            else if (busy)
                cnt <= cnt - 8'h01;
        end
    end
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "aisel_params.svh"

module tb_top
    import aisel_pkg::*;
;
    logic               core_clk, rst_n, ce, awv, wv, bry, arv, rry, done;
    logic               awr, wrdy, bv, arr, rv, start, irq, cmux;
    logic [11:0]        awa, ara;
    logic [31:0]        wd, rdat;
    logic [7:0]         trig, dly;
    logic signed [10:0] raw, craw;
    logic [1:0]         bresp, rresp;
    aisel_ref_e         reference_pin;
    aisel_route_s       route;
    int                 mismatches, n_tests, nstart, n0;
    logic [5:0]         codes [6] = '{6'd13, 6'd13, 6'd13, 6'd13, 6'd0, 6'd0};
    logic [10:0]        raws  [6] = '{11'd600, -11'sd600, -11'sd1, 11'd0, 11'd1023, -11'sd5};
    logic [9:0]         exps  [6] = '{10'h1FF, 10'h200, 10'h3FF, 10'h000, 10'h3FF, 10'h000};

    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Counts conversion start pulses
    always @(posedge core_clk)
        if (start === 1'b1)
            nstart++;

    aisel_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .conv_done(done), .conv_raw(craw), .conv_start(start),
        .active_ref(reference_pin), .active_route(route), .comparator_mux_enable(cmux),
        .trig_pins(trig), .irq(irq));

    aisel_conv_model i_conv (.clk(core_clk), .rst_n(rst_n), .conv_start(start),
        .delay(dly), .raw_in(raw), .conv_done(done), .conv_raw(craw));

    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Bus write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] er = `AISEL_RESP_OKAY);
        int k;
        @(posedge core_clk);
        awa <= {2'b00, idx, 2'b00};
        wd  <= {24'h0, d};
        awv <= 1'b1;
        wv  <= 1'b1;
        bry <= 1'b1;
        k = 0;
        do
        begin
            @(posedge core_clk);
            if (awr)
                awv <= 1'b0;
            if (wrdy)
                wv <= 1'b0;
            k++;
        end while (bv !== 1'b1 && k < 100);
        bry <= 1'b0;
        chk(bresp, er);
        if (k >= 100)
            mismatches++;
    endtask

    // Bus read: data taken at the edge that shows rvalid
    task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                      input logic [1:0] er = `AISEL_RESP_OKAY);
        int k;
        @(posedge core_clk);
        ara <= {2'b00, idx, 2'b00};
        arv <= 1'b1;
        rry <= 1'b1;
        k = 0;
        do
        begin
            @(posedge core_clk);
            if (arr)
                arv <= 1'b0;
            k++;
        end while (rv !== 1'b1 && k < 100);
        rry <= 1'b0;
        chk(rdat, {24'h0, e});
        chk(rresp, er);
        if (k >= 100)
            mismatches++;
    endtask

    // Start a conversion; wt then waits for the interrupt
    task automatic go(input logic [10:0] r);
        raw <= r;
        wr(`AISEL_IDX_CONV_CTRL, 8'h01);
    endtask

    task automatic wt;
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 300)
        begin
            @(posedge core_clk);
            k++;
        end
        if (k >= 300)
            mismatches++;
    endtask

    // Right-aligned result check, then flag clear
    task automatic res(input logic [9:0] e);
        rd(`AISEL_IDX_RESULT_LOW, e[7:0]);
        rd(`AISEL_IDX_RESULT_HIGH, {6'h00, e[9:8]});
        wr(`AISEL_IDX_IRQ_CLEAR, 8'h01);
    endtask

    // Routing expected for selection codes 0-29
    function automatic aisel_route_s exp_route(input logic [5:0] c);
        aisel_route_s x;
        x = '0;
        x.valid = 1'b1;
        if (c < 6'd8)
            x.pos = c[3:0];
        else if (c < 6'd16)
        begin
            x.diff = 1'b1;
            x.gain = c[1] ? AISEL_GAIN_200X : AISEL_GAIN_10X;
            x.pos  = {2'b00, c[2], c[0]};
            x.neg  = {2'b00, c[2], 1'b0};
        end
        else
        begin
            x.diff = 1'b1;
            x.pos  = {1'b0, c[2:0]};
            x.neg  = c[3] ? 4'h2 : 4'h1;
        end
        return x;
    endfunction

    // Watchdog
    initial
    begin
        #400000;
        mismatches++;
        end_of_test;
    end

    // Main sequence
    initial
    begin
        {awv, wv, bry, arv, rry, awa, ara, wd, trig} = '0;
        {mismatches, n_tests} = '0;
        rst_n = 1'b0;
        ce    = 1'b1;
        dly   = 8'd20;
        raw   = 11'h000;
        cyc(2);
        rst_n <= 1'b1;
        rd(`AISEL_IDX_INPUT_SEL, 8'h00);
        rd(`AISEL_IDX_CTRL_B, 8'h00);
        chk(route, exp_route(6'd0));
        wr(`AISEL_IDX_CTRL_B, 8'hFF);
        rd(`AISEL_IDX_CTRL_B, 8'h4F);
        chk(cmux, 1'b1);
        wr(`AISEL_IDX_CTRL_B, 8'h00);
        wr(`AISEL_IDX_INPUT_SEL, 8'hFF);
        rd(`AISEL_IDX_INPUT_SEL, 8'hFF);
        rd(8'h7D, 8'h00, `AISEL_RESP_SLVERR);
        wr(8'h7D, 8'h55, `AISEL_RESP_SLVERR);
        // Codes 0-25; gained and differential codes on the upper reference
        for (int c = 0; c < 26; c++)
        begin
            wr(`AISEL_IDX_INPUT_SEL, {(c < 8) ? c[1:0] : 2'd3, 1'b0, c[4:0]});
            cyc(2);
            chk(route, exp_route(c[5:0]));
            chk(reference_pin, (c < 8) ? c[1:0] : 2'd3);
        end
        // Settings held during a conversion, alignment switched afterwards
        wr(`AISEL_IDX_IRQ_ENABLE, 8'h01);
        wr(`AISEL_IDX_INPUT_SEL, 8'hED);
        go(-11'sd400);
        rd(`AISEL_IDX_CONV_CTRL, 8'h05);
        wr(`AISEL_IDX_INPUT_SEL, 8'h40);
        wr(`AISEL_IDX_CTRL_B, 8'h08);
        cyc(1);
        chk(reference_pin, 2'd3);
        chk(route, exp_route(6'd13));
        wt;
        rd(`AISEL_IDX_IRQ_STATUS, 8'h01);
        rd(`AISEL_IDX_RESULT_LOW, 8'h70);
        rd(`AISEL_IDX_RESULT_HIGH, 8'h02);
        // Extension now applies: code 100000 is single-ended input 8
        chk(route, 12'h880);
        wr(`AISEL_IDX_CTRL_B, 8'h00);
        wr(`AISEL_IDX_INPUT_SEL, 8'h60);
        rd(`AISEL_IDX_RESULT_LOW, 8'h00);
        rd(`AISEL_IDX_RESULT_HIGH, 8'h9C);
        chk(reference_pin, 2'd1);
        chk(route, exp_route(6'd0));
        wr(`AISEL_IDX_IRQ_CLEAR, 8'h01);
        rd(`AISEL_IDX_IRQ_STATUS, 8'h00);
        chk(irq, 1'b0);
        // Saturation and clamping table
        for (int i = 0; i < 6; i++)
        begin
            wr(`AISEL_IDX_INPUT_SEL, (codes[i] == 6'd0) ? 8'h00 : {3'b110, codes[i][4:0]});
            go(raws[i]);
            wt;
            res(exps[i]);
        end
        // Masked completion keeps the interrupt low until enabled
        wr(`AISEL_IDX_IRQ_ENABLE, 8'h00);
        go(11'd5);
        cyc(30);
        chk(irq, 1'b0);
        rd(`AISEL_IDX_IRQ_STATUS, 8'h01);
        wr(`AISEL_IDX_IRQ_ENABLE, 8'h01);
        cyc(2);
        chk(irq, 1'b1);
        wr(`AISEL_IDX_IRQ_CLEAR, 8'h01);
        cyc(2);
        chk(irq, 1'b0);
        // Auto trigger: only the selected pin starts a conversion
        wr(`AISEL_IDX_CTRL_B, 8'h03);
        wr(`AISEL_IDX_CONV_CTRL, 8'h02);
        rd(`AISEL_IDX_CONV_CTRL, 8'h02);
        n0 = nstart;
        trig <= 8'h04;
        cyc(6);
        chk(nstart - n0, 0);
        // A trigger edge while the clock enable is low waits for the enable
        ce   <= 1'b0;
        trig <= 8'h0C;
        cyc(6);
        chk(nstart - n0, 0);
        ce   <= 1'b1;
        cyc(6);
        chk(nstart - n0, 1);
        cyc(30);
        end_of_test;
    end
endmodule

`default_nettype wire
